// ### hdl/pgpio_regs.svh
// register indexes, reset values and field layout of the parallel port block
`ifndef PGPIO_REGS_SVH
`define PGPIO_REGS_SVH

// ----------------------------------------------------------------------------
// register indexes (byte address is four times the index)
// ----------------------------------------------------------------------------
`define PGPIO_IDX_PORT_ONE_DIRECTION 10'h0C0
`define PGPIO_IDX_PORT_TWO_DIRECTION 10'h0C1
`define PGPIO_IDX_PORT_ONE_DATA 10'h0C2
`define PGPIO_IDX_PORT_TWO_DATA 10'h0C3
`define PGPIO_IDX_PORT_THREE_DIRECTION 10'h0C4
`define PGPIO_IDX_PORT_THREE_DATA 10'h0C6
`define PGPIO_IDX_PORT_FIVE_DIRECTION 10'h0C8
`define PGPIO_IDX_PORT_FIVE_DATA 10'h0CA
`define PGPIO_IDX_PIN_LEVEL 10'h0D0

// ----------------------------------------------------------------------------
// widths, reset values and read values
// ----------------------------------------------------------------------------
`define PGPIO_FULL_WIDTH 8
`define PGPIO_NARROW_WIDTH 4
`define PGPIO_DIR_RESET 8'h00
`define PGPIO_DATA_RESET 8'h00
`define PGPIO_WO_READ 8'hFF
`define PGPIO_NARROW_RSVD 4'hF
`define PGPIO_NARROW_PAD 4'h0

`endif

// ### hdl/pgpio_pkg.sv
// types shared by the parallel port block
package pgpio_pkg;

	// ------------------------------------------------------------------------
	// pin drive carried out of the block
	// ------------------------------------------------------------------------
	typedef struct packed {
		logic [7:0] enable;
		logic [7:0] level;
	} pgpio_drive_t;

	// ------------------------------------------------------------------------
	// apb answer of the slave
	// ------------------------------------------------------------------------
	typedef struct packed {
		logic ready;
		logic slverr;
		logic [31:0] rdata;
	} pgpio_apb_rsp_t;

endpackage : pgpio_pkg

// ### hdl/pgpio_port.sv
// one port: direction and data registers with their write strobes
`timescale 1ns/1ps

module pgpio_port #(
	parameter int WIDTH = 8
) (
	// clock and reset
	input wire logic pclk,
	input wire logic presetn,
	// write strobes and data
	input wire logic wr_dir,
	input wire logic wr_data,
	input wire logic [WIDTH-1:0] wdata,
	// register state
	output logic [WIDTH-1:0] dir_reg,
	output logic [WIDTH-1:0] data_reg
);

	logic [WIDTH-1:0] dir_next;
	logic [WIDTH-1:0] data_next;

	// ------------------------------------------------------------------------
	// next values
	// ------------------------------------------------------------------------
	always_comb begin
		dir_next = dir_reg;
		data_next = data_reg;
		if (wr_dir) begin
			dir_next = wdata;
		end
		if (wr_data) begin
			data_next = wdata;
		end
	end

	// ------------------------------------------------------------------------
	// registers; all pins come up as inputs
	// ------------------------------------------------------------------------
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			dir_reg <= '0;
			data_reg <= '0;
		end else begin
			dir_reg <= dir_next;
			data_reg <= data_next;
		end
	end

endmodule // pgpio_port

// ### hdl/pgpio_top.sv
// apb register slave and pin drive for the four parallel ports
//
// The APB slave port was left to the implementer.
`timescale 1ns/1ps

`include "pgpio_regs.svh"

// Overview of operation
// - Direction bit 0 makes a pin an input; 1 drives it from the data bit.
// - Direction bits are write-only, reading no stored value; they reset to 0.
// - Data bits are read/write by software and hold each pin's data value.
// - All eight bits of each full-width data register reset to 0.
module pgpio_top (
	// clock and reset
	input wire logic pclk,
	input wire logic presetn,
	// apb slave
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [11:0] paddr,
	input wire logic [31:0] pwdata,
	input wire logic [3:0] pstrb,
	output logic [31:0] prdata,
	output logic pready,
	output logic pslverr,
	// pin levels seen from outside
	input wire logic [7:0] port_one_pins_level,
	input wire logic [7:0] port_two_pins_level,
	input wire logic [7:0] port_three_pins_level,
	input wire logic [3:0] port_five_pins_level,
	// pin drive
	output pgpio_pkg::pgpio_drive_t port_one_pins_drive,
	output pgpio_pkg::pgpio_drive_t port_two_pins_drive,
	output pgpio_pkg::pgpio_drive_t port_three_pins_drive,
	output pgpio_pkg::pgpio_drive_t port_five_pins_drive
);

	import pgpio_pkg::*;

	// ------------------------------------------------------------------------
	// bus decode
	// ------------------------------------------------------------------------
	logic [9:0] word_idx;
	logic setup_phase;
	logic write_commit;
	logic lane0_write;
	logic hit;

	assign word_idx = paddr[11:2];
	assign setup_phase = psel && !penable;
	// writes land only on the completing access edge
	assign write_commit = psel && penable && pready && pwrite;
	assign lane0_write = write_commit && pstrb[0];

	always_comb begin
		unique case (word_idx)
			`PGPIO_IDX_PORT_ONE_DIRECTION,
			`PGPIO_IDX_PORT_TWO_DIRECTION,
			`PGPIO_IDX_PORT_ONE_DATA,
			`PGPIO_IDX_PORT_TWO_DATA,
			`PGPIO_IDX_PORT_THREE_DIRECTION,
			`PGPIO_IDX_PORT_THREE_DATA,
			`PGPIO_IDX_PORT_FIVE_DIRECTION,
			`PGPIO_IDX_PORT_FIVE_DATA,
			`PGPIO_IDX_PIN_LEVEL: begin
				hit = 1'b1;
			end
			default: begin
				hit = 1'b0;
			end
		endcase
	end

	// ------------------------------------------------------------------------
	// write strobes
	// ------------------------------------------------------------------------
	logic wr_one_dir;
	logic wr_one_data;
	logic wr_two_dir;
	logic wr_two_data;
	logic wr_three_dir;
	logic wr_three_data;
	logic wr_five_dir;
	logic wr_five_data;

	assign wr_one_dir = lane0_write && (word_idx == `PGPIO_IDX_PORT_ONE_DIRECTION);
	assign wr_one_data = lane0_write && (word_idx == `PGPIO_IDX_PORT_ONE_DATA);
	assign wr_two_dir = lane0_write && (word_idx == `PGPIO_IDX_PORT_TWO_DIRECTION);
	assign wr_two_data = lane0_write && (word_idx == `PGPIO_IDX_PORT_TWO_DATA);
	assign wr_three_dir = lane0_write && (word_idx == `PGPIO_IDX_PORT_THREE_DIRECTION);
	assign wr_three_data = lane0_write && (word_idx == `PGPIO_IDX_PORT_THREE_DATA);
	assign wr_five_dir = lane0_write && (word_idx == `PGPIO_IDX_PORT_FIVE_DIRECTION);
	assign wr_five_data = lane0_write && (word_idx == `PGPIO_IDX_PORT_FIVE_DATA);

	// ------------------------------------------------------------------------
	// port registers
	// ------------------------------------------------------------------------
	logic [7:0] one_dir_reg;
	logic [7:0] one_data_reg;
	logic [7:0] two_dir_reg;
	logic [7:0] two_data_reg;
	logic [7:0] three_dir_reg;
	logic [7:0] three_data_reg;
	logic [3:0] five_dir_reg;
	logic [3:0] five_data_reg;

	pgpio_port #(.WIDTH(`PGPIO_FULL_WIDTH)) u_port_one (
		.pclk(pclk),
		.presetn(presetn),
		.wr_dir(wr_one_dir),
		.wr_data(wr_one_data),
		.wdata(pwdata[7:0]),
		.dir_reg(one_dir_reg),
		.data_reg(one_data_reg)
	);

	pgpio_port #(.WIDTH(`PGPIO_FULL_WIDTH)) u_port_two (
		.pclk(pclk),
		.presetn(presetn),
		.wr_dir(wr_two_dir),
		.wr_data(wr_two_data),
		.wdata(pwdata[7:0]),
		.dir_reg(two_dir_reg),
		.data_reg(two_data_reg)
	);

	pgpio_port #(.WIDTH(`PGPIO_FULL_WIDTH)) u_port_three (
		.pclk(pclk),
		.presetn(presetn),
		.wr_dir(wr_three_dir),
		.wr_data(wr_three_data),
		.wdata(pwdata[7:0]),
		.dir_reg(three_dir_reg),
		.data_reg(three_data_reg)
	);

	// narrow port keeps no storage for its upper bits, so writes there vanish
	pgpio_port #(.WIDTH(`PGPIO_NARROW_WIDTH)) u_port_five (
		.pclk(pclk),
		.presetn(presetn),
		.wr_dir(wr_five_dir),
		.wr_data(wr_five_data),
		.wdata(pwdata[3:0]),
		.dir_reg(five_dir_reg),
		.data_reg(five_data_reg)
	);

	// ------------------------------------------------------------------------
	// pin drive: enable follows direction, level follows data
	// ------------------------------------------------------------------------
	always_comb begin
		port_one_pins_drive = '{enable: one_dir_reg, level: one_data_reg};
		port_two_pins_drive = '{enable: two_dir_reg, level: two_data_reg};
		port_three_pins_drive = '{enable: three_dir_reg, level: three_data_reg};
		port_five_pins_drive = '{
			enable: {`PGPIO_NARROW_PAD, five_dir_reg},
			level: {`PGPIO_NARROW_PAD, five_data_reg}
		};
	end

	// ------------------------------------------------------------------------
	// pin level sampling; inputs are already synchronous to pclk
	// ------------------------------------------------------------------------
	logic [27:0] pin_level_reg;
	logic [27:0] pin_level_next;

	always_comb begin
		pin_level_next = {port_five_pins_level, port_three_pins_level,
			port_two_pins_level, port_one_pins_level};
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			pin_level_reg <= '0;
		end else begin
			pin_level_reg <= pin_level_next;
		end
	end

	// ------------------------------------------------------------------------
	// read data, picked in the setup phase so it stands for the access phase
	// ------------------------------------------------------------------------
	logic [31:0] read_word;

	always_comb begin
		read_word = 32'h0000_0000;
		unique case (word_idx)
			// direction is write-only: software never sees it back
			`PGPIO_IDX_PORT_ONE_DIRECTION,
			`PGPIO_IDX_PORT_TWO_DIRECTION,
			`PGPIO_IDX_PORT_THREE_DIRECTION,
			`PGPIO_IDX_PORT_FIVE_DIRECTION: begin
				read_word[7:0] = `PGPIO_WO_READ;
			end
			`PGPIO_IDX_PORT_ONE_DATA: begin
				read_word[7:0] = one_data_reg;
			end
			`PGPIO_IDX_PORT_TWO_DATA: begin
				read_word[7:0] = two_data_reg;
			end
			`PGPIO_IDX_PORT_THREE_DATA: begin
				read_word[7:0] = three_data_reg;
			end
			`PGPIO_IDX_PORT_FIVE_DATA: begin
				read_word[7:0] = {`PGPIO_NARROW_RSVD, five_data_reg};
			end
			`PGPIO_IDX_PIN_LEVEL: begin
				read_word[27:0] = pin_level_reg;
			end
			default: begin
				read_word = 32'h0000_0000;
			end
		endcase
	end

	// ------------------------------------------------------------------------
	// apb answer: zero wait states, error on unmapped words
	// ------------------------------------------------------------------------
	pgpio_apb_rsp_t rsp_reg;
	pgpio_apb_rsp_t rsp_next;

	always_comb begin
		rsp_next.ready = setup_phase;
		rsp_next.slverr = setup_phase && !hit;
		rsp_next.rdata = rsp_reg.rdata;
		if (setup_phase && !pwrite && hit) begin
			rsp_next.rdata = read_word;
		end else if (setup_phase) begin
			rsp_next.rdata = 32'h0000_0000;
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			rsp_reg <= '0;
		end else begin
			rsp_reg <= rsp_next;
		end
	end

	assign prdata = rsp_reg.rdata;
	assign pready = rsp_reg.ready;
	assign pslverr = rsp_reg.slverr;

endmodule // pgpio_top

// ### dv/pgpio_properties.sv
// concurrent checks on the parallel port apb slave and pin drive
`timescale 1ns/1ps
module pgpio_properties (
	// clock and reset
	input wire logic pclk,
	input wire logic presetn,
	// apb
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [11:0] paddr,
	input wire logic [31:0] pwdata,
	input wire logic [3:0] pstrb,
	input wire logic [31:0] prdata,
	input wire logic pready,
	input wire logic pslverr,
	// pin drive
	input wire pgpio_pkg::pgpio_drive_t port_one_pins_drive,
	input wire pgpio_pkg::pgpio_drive_t port_five_pins_drive
);
	import pgpio_pkg::*;
	default clocking @(posedge pclk); endclocking
	default disable iff (!presetn);
	wire [9:0] ix = paddr[11:2];
	wire setup = psel && !penable;
	wire mapped = ix inside {10'h0C0, 10'h0C1, 10'h0C2, 10'h0C3, 10'h0C4, 10'h0C6, 10'h0C8,
		10'h0CA, 10'h0D0};
	sequence s_wr(logic [9:0] i);
		setup && pwrite && pstrb[0] && ix == i ##1 pready;
	endsequence
	sequence s_rd(logic [9:0] i);
		setup && !pwrite && ix == i ##1 pready;
	endsequence
	property p_rdy;
		pready == $past(setup);
	endproperty
	property p_err;
		setup |=> pslverr == !$past(mapped);
	endproperty
	property p_dir_rd;
		s_rd(10'h0C0) |-> prdata == 32'h000000FF;
	endproperty
	property p_five_rd;
		s_rd(10'h0CA) |-> prdata[31:4] == 28'h000000F;
	endproperty
	property p_dir_wr;
		s_wr(10'h0C0) |=> port_one_pins_drive.enable == $past(pwdata[7:0]);
	endproperty
	property p_dat_wr;
		s_wr(10'h0C2) |=> port_one_pins_drive.level == $past(pwdata[7:0]);
	endproperty
	property p_hold;
		$changed(port_one_pins_drive) |->
			$past(pready && pwrite && pstrb[0] && ix inside {10'h0C0, 10'h0C2});
	endproperty
	property p_five_drv;
		{port_five_pins_drive.enable[7:4], port_five_pins_drive.level[7:4]} == 8'h00;
	endproperty
	property p_rst;
		$rose(presetn) |-> port_one_pins_drive == 16'h0000 && port_five_pins_drive == 16'h0000;
	endproperty
	a_rdy: assert property (p_rdy) else $error("pready not one cycle after setup");
	a_err: assert property (p_err) else $error("pslverr wrong for index");
	a_dir_rd: assert property (p_dir_rd) else $error("direction read not all ones");
	a_five_rd: assert property (p_five_rd) else $error("narrow port upper bits wrong");
	a_dir_wr: assert property (p_dir_wr) else $error("enable not from direction");
	a_dat_wr: assert property (p_dat_wr) else $error("level not from data");
	a_hold: assert property (p_hold) else $error("drive changed without write");
	a_five_drv: assert property (p_five_drv) else $error("narrow port upper drive set");
	a_rst: assert property (p_rst) else $error("drive not zero after reset");
endmodule // pgpio_properties

bind pgpio_top pgpio_properties i_pgpio_properties (.pclk(pclk), .presetn(presetn), .psel(psel),
	.penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb),
	.prdata(prdata), .pready(pready), .pslverr(pslverr),
	.port_one_pins_drive(port_one_pins_drive), .port_five_pins_drive(port_five_pins_drive));

// ### dv/pgpio_pin_model.sv
// external circuitry on the port pins
`timescale 1ns/1ps
module pgpio_pin_model (
	// clock
	input wire logic pclk,
	// drive from the block
	input wire pgpio_pkg::pgpio_drive_t drv_one,
	input wire pgpio_pkg::pgpio_drive_t drv_two,
	input wire pgpio_pkg::pgpio_drive_t drv_three,
	input wire pgpio_pkg::pgpio_drive_t drv_five,
	// pin levels
	output logic [7:0] lvl_one,
	output logic [7:0] lvl_two,
	output logic [7:0] lvl_three,
	output logic [3:0] lvl_five
);
	import pgpio_pkg::*;
	logic [7:0] ext = 8'hA5;
	// undriven pins change every cycle so a stale level never looks right
	always @(posedge pclk) ext <= ext + 8'h3B;
	function automatic logic [7:0] pin(pgpio_drive_t d, logic [7:0] x);
		return (d.enable & d.level) | (~d.enable & x);
	endfunction
	assign lvl_one = pin(drv_one, ext);
	assign lvl_two = pin(drv_two, ext);
	assign lvl_three = pin(drv_three, ext);
	assign lvl_five = (drv_five.enable[3:0] & drv_five.level[3:0])
		| (~drv_five.enable[3:0] & ext[3:0]);
endmodule // pgpio_pin_model

// ### dv/test_pgpio_top.sv
// self-checking bench for the parallel port block
`timescale 1ns/1ps
`define CHK(nm, e, g) begin checks++; if ((g) !== (e)) begin n_fail++; \
	$display("MISMATCH %s exp %h got %h", nm, e, g); end end
module test_pgpio_top;
	import pgpio_pkg::*;
	logic pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0;
	logic [11:0] paddr = 12'h000;
	logic [31:0] pwdata = 32'h0, prdata;
	logic [3:0] pstrb = 4'hF;
	logic pready, pslverr;
	logic [7:0] l1, l2, l3;
	logic [3:0] l5;
	pgpio_drive_t d1, d2, d3, d5;
	logic [32:0] expq[$];
	logic [32:0] exp_v;
	int n_fail = 0, checks = 0;
	localparam logic [9:0] DIRS [4] = '{10'h0C0, 10'h0C1, 10'h0C4, 10'h0C8};
	localparam logic [9:0] DATS [4] = '{10'h0C2, 10'h0C3, 10'h0C6, 10'h0CA};
	always #10 pclk = ~pclk;
	pgpio_top i_pgpio_top (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
		.pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb), .prdata(prdata),
		.pready(pready), .pslverr(pslverr), .port_one_pins_level(l1), .port_two_pins_level(l2),
		.port_three_pins_level(l3), .port_five_pins_level(l5), .port_one_pins_drive(d1),
		.port_two_pins_drive(d2), .port_three_pins_drive(d3), .port_five_pins_drive(d5));
	pgpio_pin_model i_pgpio_pin_model (.pclk(pclk), .drv_one(d1), .drv_two(d2), .drv_three(d3),
		.drv_five(d5), .lvl_one(l1), .lvl_two(l2), .lvl_three(l3), .lvl_five(l5));
	function automatic pgpio_drive_t drv(int p);
		return p == 0 ? d1 : p == 1 ? d2 : p == 2 ? d3 : d5;
	endfunction
	task test_done;
		$display("checks %0d n_fail %0d", checks, n_fail);
		if (n_fail == 0 && checks > 0) $display("RESULT: PASS");
		else $display("RESULT: FAIL");
		$finish;
	endtask
	// master holds everything until pready; psel stays up for back to back
	task automatic apb(logic w, logic [9:0] ix, logic [7:0] d, logic [3:0] s, logic [32:0] e);
		int n = 0;
		psel <= 1'b1;
		pwrite <= w;
		paddr <= {ix, 2'b00};
		pwdata <= {24'h000000, d};
		pstrb <= s;
		if (!w) expq.push_back(e);
		@(posedge pclk);
		penable <= 1'b1;
		do begin @(posedge pclk); n++; end while (pready !== 1'b1 && n < 20);
		if (n >= 20) begin n_fail++; test_done(); end
		penable <= 1'b0;
	endtask
	task idle;
		psel <= 1'b0;
		@(posedge pclk);
	endtask
	task reset_check;
		presetn <= 1'b0;
		repeat (2) @(posedge pclk);
		presetn <= 1'b1;
		for (int p = 0; p < 4; p++) `CHK("drive at reset", 16'h0000, drv(p))
		for (int p = 0; p < 4; p++) begin
			apb(1'b0, DATS[p], 8'h00, 4'hF, {25'h0, p == 3 ? 8'hF0 : 8'h00});
			apb(1'b0, DIRS[p], 8'h00, 4'hF, {25'h0, 8'hFF});
		end
		idle();
	endtask
	always @(posedge pclk) begin
		if (psel && penable && pready === 1'b1 && !pwrite) begin
			exp_v = expq.size() > 0 ? expq.pop_front() : 'x;
			`CHK("read", exp_v, {pslverr, prdata})
		end
	end
	initial begin
		logic [31:0] v, u;
		logic [7:0] m;
		void'($urandom(32'hEFDDDAA1));
		reset_check();
		for (int k = 0; k < 3; k++) begin
			for (int p = 0; p < 4; p++) begin
				v = $urandom;
				u = $urandom;
				m = p == 3 ? 8'h0F : 8'hFF;
				apb(1'b1, DIRS[p], v[7:0], 4'hF, '0);
				apb(1'b1, DATS[p], u[7:0], 4'hF, '0);
				apb(1'b1, DATS[p], ~u[7:0], 4'hE, '0);
				apb(1'b0, DATS[p], 8'h00, 4'hF, {25'h0, u[7:0] | ~m});
				apb(1'b0, DIRS[p], 8'h00, 4'hF, {25'h0, 8'hFF});
				idle();
				`CHK("enable", v[7:0] & m, drv(p).enable)
				`CHK("level", u[7:0] & m, drv(p).level)
			end
		end
		// every pin driven, so the sampled level word is fully known
		u = $urandom;
		for (int p = 0; p < 4; p++) begin
			apb(1'b1, DIRS[p], 8'hFF, 4'hF, '0);
			apb(1'b1, DATS[p], u[8*p +: 8], 4'hF, '0);
		end
		// one idle edge lets the level sampler catch the last write
		idle();
		apb(1'b0, 10'h0D0, 8'h00, 4'hF, {5'h00, u[27:0]});
		idle();
		apb(1'b1, 10'h3FE, 8'h5A, 4'hF, '0);
		apb(1'b0, 10'h3FF, 8'h00, 4'hF, {1'b1, 32'h0});
		idle();
		reset_check();
		test_done();
	end
endmodule // test_pgpio_top
